/* File: logic/dma_ctrl_pkg.sv */
// Purpose: Shared constants and carriers for the DMA interrupt and bus-mode slice
// Assumes: 8-bit register port, one clock
// Notes: Offsets and field positions live here only
package dma_ctrl_pkg;
  localparam logic [3:0] OFS_IRQ_EN = 4'h0;
  localparam logic [3:0] OFS_CHAN_CTRL = 4'h1;
  localparam logic [3:0] OFS_BUS_CTRL = 4'h2;
  localparam logic [3:0] OFS_STATUS = 4'h3;
  localparam logic [3:0] OFS_XFER_CNT0 = 4'h4;
  localparam logic [3:0] OFS_XFER_CNT1 = 4'h5;
  // Interrupt enable register fields
  localparam int BIT_CH0_END = 0;
  localparam int BIT_CH0_BRK = 1;
  localparam int BIT_CH1_END = 2;
  localparam int BIT_CH1_BRK = 3;
  // Channel control: per channel four bits, stride 4
  localparam int BIT_XFER_EN = 0;
  localparam int BIT_MASTER_EN = 1;
  localparam int BIT_AUTO_REQ = 2;
  localparam int BIT_BURST = 3;
  localparam int CH_STRIDE = 4;
  // Bus control fields
  localparam int BIT_WBUF_EN = 1;
  localparam int BIT_ACK_SEL = 3;
  localparam logic [7:0] IRQ_EN_RESET = 8'h00;
  localparam logic [7:0] BUS_CTRL_RESET = 8'h08;
  localparam logic [7:0] CHAN_CTRL_RESET = 8'h00;
  localparam logic [1:0] ACK_STATE_FULL = 2'h0;
  localparam logic [1:0] ACK_STATE_BURST = 2'h1;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  typedef struct packed {
    logic [7:0] data;
    logic last;
  } xfer_word_t;

  typedef enum logic [2:0] {
    BUS_IDLE = 3'b001,
    BUS_OWN = 3'b010,
    BUS_GIVE = 3'b100
  } bus_state_t;
endpackage

/* File: logic/dma_irq_bus_ctrl.sv */
// Purpose: Two-channel DMA interrupt requests, activation and bus holding
// Assumes: Register port strobes from same clock; external requests async
// Notes:
// Notes on behaviour
// - Break enable set while master enable clear raises break request.
// - Break request drops on break enable clear or master enable set.
// - End enable set while transfer enable clear raises end request.
// - End request drops on end enable clear or transfer enable set.
// - Bit 3 is channel 1 break enable, resets to 0.
// - Bit 1 is channel 0 break enable, resets to 0.
// - Bit 2 is channel 1 end enable, resets to 0.
// - Bit 0 is channel 0 end enable, resets to 0.
// - Channel starts from external request or internal auto-request.
// - Auto-request runs the programmed count with no further requests.
// - Cycle-steal releases the bus after every transfer; the code releases it only while otherBusReq is high.
// - Burst mode keeps the bus until the whole count is done.
// - Ack select 0: full accesses, ack low from first state.
// - Ack select 1 (reset): burst allowed, ack low from second state.
// - Write buffer enable chooses buffered writes, resets to 0.
//
// Added by the designer: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module dma_irq_bus_ctrl
  import dma_ctrl_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register port
  input wire reg_req_t regReq,
  output logic [7:0] regRdata,
  // External transfer requests (async pins)
  input wire logic [1:0] extReq,
  // System bus arbitration
  input wire logic otherBusReq,
  output logic busOwn,
  output logic transferAckStrobeN,
  output logic writeBufferActive,
  output logic burstAccessAllowed,
  // Transfer word stream out through a two-entry buffer
  output xfer_word_t outWord,
  output logic outValid,
  input wire logic outReady,
  // Interrupt request lines
  output logic [1:0] endIrq,
  output logic [1:0] breakIrq
);

  typedef struct packed {
    logic [7:0] irqEn;
    logic [7:0] chanCtrl;
    logic [7:0] busCtrl;
    logic [7:0] cnt0;
    logic [7:0] cnt1;
    logic [7:0] rdata;
    logic [1:0] extSync1;
    logic [1:0] extSync2;
    logic [1:0] pending;
    bus_state_t bus;
    logic activeCh;
    logic [1:0] ackPhase;
    logic ackN;
    xfer_word_t buf0;
    xfer_word_t buf1;
    logic [1:0] bufCnt;
    logic [1:0] endIrq;
    logic [1:0] breakIrq;
    logic wbufAct;
    logic burstOk;
    // Registered copies so the ownership and valid outputs leave a flop directly
    logic ownQ;
    logic validQ;
  } state_t;

  state_t state_reg;
  state_t state_next;
  logic [7:0] cntCur;
  logic chXferEn;
  logic chBurst;
  logic canPush;
  logic pushWord;
  logic popWord;

  ////////////////////////////////////////////////////////////////////////
  // Combinational next state
  always_comb begin
    state_next = state_reg;
    // Second flop alone reads the first
    state_next.extSync1 = extReq;
    state_next.extSync2 = state_reg.extSync1;
    cntCur = state_reg.activeCh ? state_reg.cnt1 : state_reg.cnt0;
    chXferEn = state_reg.chanCtrl[state_reg.activeCh*CH_STRIDE + BIT_XFER_EN];
    chBurst = state_reg.chanCtrl[state_reg.activeCh*CH_STRIDE + BIT_BURST];
    // Buffer full stalls transfers so a stalled receiver loses no word
    canPush = (state_reg.bufCnt != 2'h2);
    pushWord = 1'b0;
    popWord = state_reg.bufCnt != 2'h0 && outReady;

    // Register writes
    if (regReq.wr) begin
      case (regReq.addr)
        OFS_IRQ_EN: state_next.irqEn = {4'h0, regReq.wdata[3:0]};
        OFS_CHAN_CTRL: state_next.chanCtrl = regReq.wdata;
        OFS_BUS_CTRL: state_next.busCtrl = regReq.wdata & 8'h0A;
        OFS_XFER_CNT0: state_next.cnt0 = regReq.wdata;
        OFS_XFER_CNT1: state_next.cnt1 = regReq.wdata;
        default: ;
      endcase
    end

    // Activation: external pin or auto-request per channel
    for (int c = 0; c < 2; c++) begin
      if (state_reg.chanCtrl[c*CH_STRIDE + BIT_XFER_EN] &&
          state_reg.chanCtrl[c*CH_STRIDE + BIT_MASTER_EN] &&
          (state_reg.chanCtrl[c*CH_STRIDE + BIT_AUTO_REQ] || state_reg.extSync2[c])) begin
        state_next.pending[c] = 1'b1;
      end else begin
        state_next.pending[c] = 1'b0;
      end
    end

    // Bus ownership state machine
    state_next.ackN = 1'b1;
    case (state_reg.bus)
      BUS_IDLE: begin
        state_next.ackPhase = 2'h0;
        if (state_reg.pending[0]) begin
          state_next.activeCh = 1'b0;
          state_next.bus = BUS_OWN;
        end else if (state_reg.pending[1]) begin
          state_next.activeCh = 1'b1;
          state_next.bus = BUS_OWN;
        end
      end
      BUS_OWN: begin
        // Phase 0 is first state, phase 1 second
        if (state_reg.ackPhase == ACK_STATE_FULL) begin
          state_next.ackPhase = ACK_STATE_BURST;
          state_next.ackN = state_reg.busCtrl[BIT_ACK_SEL];
        end else if (!chXferEn || cntCur == 8'h00) begin
          state_next.bus = BUS_GIVE;
        end else if (canPush) begin
          state_next.ackN = 1'b0;
          pushWord = 1'b1;
          if (state_reg.activeCh) begin
            state_next.cnt1 = state_reg.cnt1 - 8'h01;
          end else begin
            state_next.cnt0 = state_reg.cnt0 - 8'h01;
          end
          if (cntCur == 8'h01) begin
            // Count exhausted: clear transfer enable, hand back bus
            state_next.chanCtrl[state_reg.activeCh*CH_STRIDE + BIT_XFER_EN] = 1'b0;
            state_next.bus = BUS_GIVE;
          end else if (!chBurst && otherBusReq) begin
            state_next.bus = BUS_GIVE;
          end else if (!chBurst) begin
            state_next.ackPhase = ACK_STATE_FULL;
          end
        end
      end
      BUS_GIVE: begin
        // One idle cycle lets another master take the bus
        state_next.bus = BUS_IDLE;
        state_next.ackPhase = 2'h0;
      end
      default: state_next.bus = BUS_IDLE;
    endcase

    // Two-entry output buffer
    if (popWord) begin
      state_next.buf0 = state_reg.buf1;
    end
    if (pushWord) begin
      if ((popWord ? state_reg.bufCnt - 2'h1 : state_reg.bufCnt) == 2'h0) begin
        state_next.buf0 = '{data: cntCur, last: cntCur == 8'h01};
      end else begin
        state_next.buf1 = '{data: cntCur, last: cntCur == 8'h01};
      end
    end
    state_next.bufCnt = state_reg.bufCnt + {1'b0, pushWord} - {1'b0, popWord};

    // Level interrupt requests, one pair per channel, from new values
    for (int c = 0; c < 2; c++) begin
      state_next.endIrq[c] = state_next.irqEn[2*c] &&
          !state_next.chanCtrl[c*CH_STRIDE + BIT_XFER_EN];
      state_next.breakIrq[c] = state_next.irqEn[2*c+1] &&
          !state_next.chanCtrl[c*CH_STRIDE + BIT_MASTER_EN];
    end
    state_next.wbufAct = state_next.busCtrl[BIT_WBUF_EN];
    state_next.burstOk = state_next.busCtrl[BIT_ACK_SEL];
    // Output flags from next state, so they line up with the bus and buffer
    state_next.ownQ = state_next.bus == BUS_OWN;
    state_next.validQ = state_next.bufCnt != 2'h0;

    // Read data one cycle after the strobe
    state_next.rdata = 8'h00;
    if (regReq.rd) begin
      case (regReq.addr)
        OFS_IRQ_EN: state_next.rdata = state_reg.irqEn;
        OFS_CHAN_CTRL: state_next.rdata = state_reg.chanCtrl;
        OFS_BUS_CTRL: state_next.rdata = state_reg.busCtrl | 8'h04;
        OFS_STATUS: state_next.rdata = {state_reg.breakIrq, state_reg.endIrq,
                                        state_reg.bus == BUS_OWN, state_reg.activeCh,
                                        state_reg.bufCnt};
        OFS_XFER_CNT0: state_next.rdata = state_reg.cnt0;
        OFS_XFER_CNT1: state_next.rdata = state_reg.cnt1;
        default: state_next.rdata = 8'h00;
      endcase
    end

    if (rst) begin
      state_next = '0;
      state_next.irqEn = IRQ_EN_RESET;
      state_next.chanCtrl = CHAN_CTRL_RESET;
      state_next.busCtrl = BUS_CTRL_RESET;
      state_next.bus = BUS_IDLE;
      state_next.ackN = 1'b1;
      state_next.burstOk = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge clk) begin
    state_reg <= state_next;
  end

  // Outputs straight from flops
  assign regRdata = state_reg.rdata;
  assign busOwn = state_reg.ownQ;
  assign transferAckStrobeN = state_reg.ackN;
  assign writeBufferActive = state_reg.wbufAct;
  assign burstAccessAllowed = state_reg.burstOk;
  assign outWord = state_reg.buf0;
  assign outValid = state_reg.validQ;
  assign endIrq = state_reg.endIrq;
  assign breakIrq = state_reg.breakIrq;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  // A register write in the same cycle may legally change the cause, so it is left out
  chk_break_raise: assert property (@(posedge clk) disable iff (rst)
    state_reg.irqEn[BIT_CH0_BRK] && !state_reg.chanCtrl[BIT_MASTER_EN] && !regReq.wr
    |=> breakIrq[0])
    else $error("break request not raised");
  chk_brk1_raise: assert property (@(posedge clk) disable iff (rst)
    state_reg.irqEn[BIT_CH1_BRK] && !state_reg.chanCtrl[CH_STRIDE + BIT_MASTER_EN] &&
    !regReq.wr |=> breakIrq[1])
    else $error("channel 1 break request not raised");
  chk_end0_raise: assert property (@(posedge clk) disable iff (rst)
    state_reg.irqEn[BIT_CH0_END] && !state_reg.chanCtrl[BIT_XFER_EN] && !regReq.wr
    |=> endIrq[0])
    else $error("channel 0 end request not raised");
  chk_break_drop: assert property (@(posedge clk) disable iff (rst)
    regReq.wr && regReq.addr == OFS_CHAN_CTRL && regReq.wdata[BIT_MASTER_EN] |=> !breakIrq[0])
    else $error("break request not dropped");
  chk_end_raise: assert property (@(posedge clk) disable iff (rst)
    state_reg.irqEn[BIT_CH1_END] && !state_reg.chanCtrl[CH_STRIDE + BIT_XFER_EN] &&
    !regReq.wr |=> endIrq[1])
    else $error("end request not raised");
  chk_end_drop: assert property (@(posedge clk) disable iff (rst)
    regReq.wr && regReq.addr == OFS_IRQ_EN && !regReq.wdata[BIT_CH0_END] |=> !endIrq[0])
    else $error("end request not dropped");
  chk_enable_bits: assert property (@(posedge clk) disable iff (rst)
    regReq.wr && regReq.addr == OFS_IRQ_EN |=> state_reg.irqEn == {4'h0, $past(regReq.wdata[3:0])})
    else $error("enable bits not stored");
  // Channel 0 enable bits and the channel 1 end bit reach their own request lines one cycle after the write
  chk_ch0_brk_bit: assert property (@(posedge clk) disable iff (rst)
    regReq.wr && regReq.addr == OFS_IRQ_EN |=>
    breakIrq[0] == ($past(regReq.wdata[BIT_CH0_BRK]) && !state_reg.chanCtrl[BIT_MASTER_EN]))
    else $error("channel 0 break enable bit wrong");
  chk_ch1_end_bit: assert property (@(posedge clk) disable iff (rst)
    regReq.wr && regReq.addr == OFS_IRQ_EN |=>
    endIrq[1] == ($past(regReq.wdata[BIT_CH1_END]) && !state_reg.chanCtrl[CH_STRIDE]))
    else $error("channel 1 end enable bit wrong");
  chk_ch0_end_bit: assert property (@(posedge clk) disable iff (rst)
    regReq.wr && regReq.addr == OFS_IRQ_EN |=>
    endIrq[0] == ($past(regReq.wdata[BIT_CH0_END]) && !state_reg.chanCtrl[BIT_XFER_EN]))
    else $error("channel 0 end enable bit wrong");
  // Channel 0 pending seen in idle must own the bus on the next cycle
  chk_pend_start: assert property (@(posedge clk) disable iff (rst)
    state_reg.bus == BUS_IDLE && state_reg.pending[0] |=> busOwn)
    else $error("pending channel not started");
  chk_count_step: assert property (@(posedge clk) disable iff (rst)
    pushWord && !state_reg.activeCh |=> state_reg.cnt0 == $past(state_reg.cnt0) - 8'h01)
    else $error("count not stepped per transfer");
  chk_buf_bound: assert property (@(posedge clk) disable iff (rst)
    state_reg.bufCnt <= 2'h2)
    else $error("output buffer overfilled");
  // Release is decided in the cycle that moves a word
  chk_steal_release: assert property (@(posedge clk) disable iff (rst)
    state_reg.bus == BUS_OWN && pushWord && !chBurst && otherBusReq |=> !busOwn)
    else $error("bus kept in cycle steal");
  chk_burst_hold: assert property (@(posedge clk) disable iff (rst)
    busOwn && chBurst && chXferEn && cntCur > 8'h01 |=> busOwn)
    else $error("bus dropped during burst");
  chk_ack_select: assert property (@(posedge clk) disable iff (rst)
    $rose(busOwn) && !state_reg.busCtrl[BIT_ACK_SEL] |=> !transferAckStrobeN)
    else $error("ack not low from first state");
  chk_ack_late: assert property (@(posedge clk) disable iff (rst)
    $rose(busOwn) && state_reg.busCtrl[BIT_ACK_SEL] |=> transferAckStrobeN)
    else $error("ack low too early");
  chk_wbuf_follow: assert property (@(posedge clk) disable iff (rst)
    regReq.wr && regReq.addr == OFS_BUS_CTRL |=> writeBufferActive == $past(regReq.wdata[BIT_WBUF_EN]))
    else $error("write buffer enable not followed");
endmodule
`default_nettype wire

/* File: testbench/bus_partner_model.sv */
// Purpose: Far side of the transfer path: word receiver and a rival bus master
// Assumes: Same clock as the controller
// Notes: Ready drops every other cycle on request so the two-entry buffer fills
`timescale 1ns/1ps
`default_nettype none
module bus_partner_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Bench controls
  input wire logic stall,
  input wire logic busWanted,
  // Stream and arbitration
  input wire logic outValid,
  output logic outReady,
  output logic otherBusReq
);
  logic phase_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Slow receiver: a stalling sink is the case that loses words in a weak buffer
  always_ff @(posedge clk) begin
    if (rst) begin
      phase_reg <= 1'b0;
    end else begin
      phase_reg <= ~phase_reg;
    end
  end
  assign outReady = ~(stall && phase_reg);
  // Rival master holds its request as a level
  assign otherBusReq = busWanted;
endmodule
`default_nettype wire

/* File: testbench/dma_irq_bus_ctrl_test.sv */
// Purpose: Self-checking bench for the DMA interrupt and bus-mode slice
// Assumes: Register port as in the package; partner model on the stream side
// Notes: Counts of words, last flags and bus drops are kept by a monitor
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("MISMATCH %s exp %0h got %0h", n, e, g); end end
module dma_irq_bus_ctrl_test;
  import dma_ctrl_pkg::*;
  logic clk, rst, stall, busWanted, otherBusReq, outReady, outValid, busOwn;
  logic transferAckStrobeN, writeBufferActive, burstAccessAllowed, prevOwn, prevOwn2, ackFirst;
  logic [1:0] extReq, endIrq, breakIrq;
  logic [7:0] regRdata;
  reg_req_t regReq;
  xfer_word_t outWord;
  int error_cnt, checks, words, lasts, falls, sums, w0, l0, f0, s0, i;

  dma_irq_bus_ctrl dut (.clk(clk), .rst(rst), .regReq(regReq), .regRdata(regRdata),
    .extReq(extReq), .otherBusReq(otherBusReq), .busOwn(busOwn),
    .transferAckStrobeN(transferAckStrobeN), .writeBufferActive(writeBufferActive),
    .burstAccessAllowed(burstAccessAllowed), .outWord(outWord), .outValid(outValid),
    .outReady(outReady), .endIrq(endIrq), .breakIrq(breakIrq));
  bus_partner_model partner (.clk(clk), .rst(rst), .stall(stall), .busWanted(busWanted),
    .outValid(outValid), .outReady(outReady), .otherBusReq(otherBusReq));

  ////////////////////////////////////////////////////////////////////////////
  // Clock and stream monitor
  always #25 clk = ~clk;
  always @(posedge clk) begin
    prevOwn <= busOwn;
    prevOwn2 <= prevOwn;
    if (outValid && outReady) words <= words + 1;
    if (outValid && outReady) sums <= sums + int'(outWord.data);
    if (outValid && outReady && outWord.last) lasts <= lasts + 1;
    if (prevOwn && !busOwn) falls <= falls + 1;
    // Strobe level in the second owned cycle tells the two timings apart
    if (busOwn && prevOwn && !prevOwn2) ackFirst <= transferAckStrobeN;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register port tasks: strobes last one cycle, read data one cycle later
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk) regReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk) regReq.wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk) regReq <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk) regReq.rd <= 1'b0;
    #1 `CHK("regRdata", e, regRdata)
  endtask
  // Interrupt lines settle one cycle after the write
  task automatic irq(input logic [1:0] e, input logic [1:0] b);
    @(posedge clk);
    #1 `CHK("endIrq", e, endIrq)
    `CHK("breakIrq", b, breakIrq)
  endtask
  // One programmed transfer, then its counts and end request
  task automatic xfer(input int ch, input logic [7:0] c, input int n, input int f,
                      input logic ack);
    w0 = words;
    l0 = lasts;
    f0 = falls;
    s0 = sums;
    wr(OFS_XFER_CNT0 + 4'(ch), 8'(n));
    wr(OFS_CHAN_CTRL, c);
    wr(OFS_IRQ_EN, 8'h01 << (2 * ch));
    for (i = 0; i < 500 && endIrq[ch] !== 1'b1; i++) @(posedge clk);
    repeat (12) @(posedge clk);
    `CHK("words", n, words - w0)
    `CHK("lasts", 1, lasts - l0)
    `CHK("dataSum", n * (n + 1) / 2, sums - s0)
    `CHK("busDrops", f, falls - f0)
    `CHK("ackFirst", ack, ackFirst)
    `CHK("endIrq", 1'b1, endIrq[ch])
    rd(OFS_CHAN_CTRL, c & ~(8'h01 << (4 * ch)));
    $display("Test transfer on channel %0d done", ch);
  endtask

  task automatic stop_test;
    $display("Comparisons %0d, mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog: whole run takes well under a thousand cycles
  initial begin
    #2000000;
    error_cnt++;
    stop_test;
  end

  // Main sequence
  initial begin
    {clk, stall, busWanted, prevOwn, prevOwn2, ackFirst} = '0;
    rst = 1'b1;
    regReq = '0;
    extReq = 2'b00;
    {error_cnt, checks, words, lasts, falls, sums} = '0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    #1 `CHK("ackStrobe", 1'b1, transferAckStrobeN)
    `CHK("burstAllowed", 1'b1, burstAccessAllowed)
    `CHK("writeBuffer", 1'b0, writeBufferActive)
    rd(OFS_IRQ_EN, IRQ_EN_RESET);
    rd(OFS_BUS_CTRL, 8'h0C);
    rd(4'hF, 8'h00);
    $display("Test reset values done");
    for (int b = 0; b < 4; b++) begin
      wr(OFS_IRQ_EN, 8'h01 << b);
      irq({b == 2, b == 0}, {b == 3, b == 1});
    end
    wr(OFS_IRQ_EN, 8'h0F);
    wr(OFS_CHAN_CTRL, 8'h22);
    irq(2'b11, 2'b00);
    wr(OFS_CHAN_CTRL, 8'h00);
    irq(2'b11, 2'b11);
    wr(OFS_IRQ_EN, 8'h05);
    irq(2'b11, 2'b00);
    wr(OFS_CHAN_CTRL, 8'h33);
    irq(2'b00, 2'b00);
    wr(OFS_IRQ_EN, 8'h00);
    $display("Test interrupt requests done");
    stall <= 1'b1;
    busWanted <= 1'b1;
    xfer(0, 8'h0F, 3, 1, 1'b1);
    wr(OFS_BUS_CTRL, 8'h06);
    rd(OFS_BUS_CTRL, 8'h06);
    `CHK("writeBuffer", 1'b1, writeBufferActive)
    `CHK("burstAllowed", 1'b0, burstAccessAllowed)
    xfer(0, 8'h07, 3, 3, 1'b0);
    extReq <= 2'b10;
    xfer(1, 8'h30, 2, 2, 1'b0);
    extReq <= 2'b00;
    stop_test;
  end
endmodule
`default_nettype wire
